/* File: rtl/brt_engine.sv */
// boundary run-test engine: op select, pin cells, test algorithms
// Contract
// - operation chosen from the low three bits of the select register only
// - operations run only with run-test instruction loaded in Run-Test/Idle
// - X00 toggle, X01 40-bit pattern, X10 40-bit signature
// - 011 signature plus pattern 20-bit; 111 signature plus count 20-bit
// - control cells 47..36 excluded; cells 47..46 still gate output drive
// - run only when direction enables differ, else behave as bypass
// - toggle mode: input-mode cells capture their pins each rising TCK
// - toggle mode: output cells invert on rise, drive pins on fall
// - pattern mode: 40-bit LFSR on rise, output-side shadows and pins on fall
// - signature mode: input pins folded into 40-bit signature on rise
// - 40-bit signature: output shadows hold and keep driving pins
// - combined mode: 20-bit signature in, 20-bit pattern out
// - count mode: output cells count up, inputs build 20-bit signature
// - distinct feedback arrangement per enabled direction
// - select register unchanged during capture
`timescale 1ns/1ps
`default_nettype none
module brt_engine (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_tck,
    input wire logic i_tdi,
    input wire logic i_run_test_instr,
    input wire logic i_run_idle,
    input wire logic i_opsel_shift,
    input wire logic i_chain_shift,
    input wire logic i_chain_update,
    input wire logic [19:0] i_a_pin,
    input wire logic [19:0] i_b_pin,
    output logic [19:0] o_a_pin,
    output logic o_a_oe_n,
    output logic [19:0] o_b_pin,
    output logic o_b_oe_n,
    output logic o_opsel_tdo,
    output logic o_chain_tdo,
    output logic o_test_active
);
    localparam int SYNC_W = 7 + 2 * brt_pkg::HALF_W;

    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_in;
    logic tck_s;
    logic tdi_s;
    logic run_instr_s;
    logic run_idle_s;
    logic opsel_shift_s;
    logic chain_shift_s;
    logic chain_update_s;
    logic [19:0] a_s;
    logic [19:0] b_s;

    logic tck_prev_q;
    logic tck_prev_d;
    logic [2:0] opsel_q;
    logic [2:0] opsel_d;
    logic [47:36] ctrl_q;
    logic [47:36] ctrl_d;
    logic [39:0] io_q;
    logic [39:0] io_d;
    logic [39:0] shadow_q;
    logic [39:0] shadow_d;

    logic tck_rise;
    logic tck_fall;
    logic active;
    logic dir_ab;
    brt_pkg::brt_mode_t mode;
    logic [19:0] out_half;
    logic [19:0] in_half;
    logic [19:0] in_pins;
    logic [19:0] out_nx;
    logic [19:0] in_nx;

    assign raw_in = {i_tck, i_tdi, i_run_test_instr, i_run_idle,
                     i_opsel_shift, i_chain_shift, i_chain_update,
                     i_b_pin, i_a_pin};

    // tck and tap levels share one latency, so their relative timing holds
    brt_sync #(.WIDTH(SYNC_W)) u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_async(raw_in),
        .o_sync(sync_in)
    );

    assign {tck_s, tdi_s, run_instr_s, run_idle_s, opsel_shift_s,
            chain_shift_s, chain_update_s, b_s, a_s} = sync_in;

    function automatic logic [39:0] prpg40(input logic [39:0] v);
        logic fb;
        fb = v[brt_pkg::TAP40_A] ^ v[brt_pkg::TAP40_B]
           ^ v[brt_pkg::TAP40_C] ^ v[brt_pkg::TAP40_D];
        return {v[38:0], fb};
    endfunction : prpg40

    function automatic logic [19:0] prpg20(input logic [19:0] v);
        logic fb;
        fb = v[brt_pkg::TAP20_A] ^ v[brt_pkg::TAP20_B];
        return {v[18:0], fb};
    endfunction : prpg20

    assign tck_rise = tck_s & ~tck_prev_q;
    assign tck_fall = ~tck_s & tck_prev_q;
    assign mode = brt_pkg::decode_op(opsel_q);
    assign dir_ab = ~ctrl_q[brt_pkg::OE_AB_POS];
    assign active = run_instr_s & run_idle_s
                  & (ctrl_q[brt_pkg::OE_AB_POS] != ctrl_q[brt_pkg::OE_BA_POS]);
    // a-to-b drives the b port, so b cells are the output half
    assign out_half = dir_ab ? io_q[39:20] : io_q[19:0];
    assign in_half = dir_ab ? io_q[19:0] : io_q[39:20];
    assign in_pins = dir_ab ? a_s : b_s;

    always_comb begin
        out_nx = out_half;
        in_nx = in_half;
        case (mode)
            brt_pkg::MODE_TOGGLE: begin
                in_nx = in_pins;
                out_nx = ~out_half;
            end
            brt_pkg::MODE_PRPG40: begin
                {out_nx, in_nx} = prpg40({out_half, in_half});
            end
            brt_pkg::MODE_PSA40: begin
                {out_nx, in_nx} = prpg40({out_half, in_half})
                                ^ {20'h0, in_pins};
            end
            brt_pkg::MODE_PSA_PRPG20: begin
                in_nx = prpg20(in_half) ^ in_pins;
                out_nx = prpg20(out_half);
            end
            brt_pkg::MODE_PSA_COUNT20: begin
                in_nx = prpg20(in_half) ^ in_pins;
                out_nx = out_half + 20'h1;
            end
            default: begin
                out_nx = out_half;
                in_nx = in_half;
            end
        endcase
    end

    always_comb begin
        tck_prev_d = tck_prev_q;
        opsel_d = opsel_q;
        ctrl_d = ctrl_q;
        io_d = io_q;
        shadow_d = shadow_q;
        if (i_clk_en) begin
            tck_prev_d = tck_s;
            if (tck_rise) begin
                // only shift alters the select register; no capture load
                if (opsel_shift_s) begin
                    opsel_d = {tdi_s, opsel_q[2:1]};
                end
                if (active) begin
                    // control cells are left out of every algorithm
                    ctrl_d = ctrl_q;
                    // halves swap with direction, so feedback order differs
                    io_d = dir_ab ? {out_nx, in_nx} : {in_nx, out_nx};
                end else if (chain_shift_s) begin
                    {ctrl_d, io_d} = {tdi_s, ctrl_q, io_q[39:1]};
                end
            end
            if (tck_fall) begin
                if (active) begin
                    // input-side shadows never move; signature-40 holds all
                    if (mode != brt_pkg::MODE_PSA40) begin
                        if (dir_ab) begin
                            shadow_d[39:20] = io_q[39:20];
                        end else begin
                            shadow_d[19:0] = io_q[19:0];
                        end
                    end
                end else if (chain_update_s) begin
                    shadow_d = io_q;
                end
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            tck_prev_q <= 1'b0;
            opsel_q <= brt_pkg::OPSEL_RESET;
            ctrl_q <= brt_pkg::CTRL_RESET;
            io_q <= brt_pkg::IO_RESET;
            shadow_q <= brt_pkg::SHADOW_RESET;
        end else begin
            tck_prev_q <= tck_prev_d;
            opsel_q <= opsel_d;
            ctrl_q <= ctrl_d;
            io_q <= io_d;
            shadow_q <= shadow_d;
        end
    end

    assign o_a_pin = shadow_q[19:0];
    assign o_b_pin = shadow_q[39:20];
    // outside test mode the normal path owns the pins, so stay released
    assign o_b_oe_n = run_instr_s ? ctrl_q[brt_pkg::OE_AB_POS] : 1'b1;
    assign o_a_oe_n = run_instr_s ? ctrl_q[brt_pkg::OE_BA_POS] : 1'b1;
    assign o_opsel_tdo = opsel_q[0];
    assign o_chain_tdo = io_q[0];
    assign o_test_active = active;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    chk_idle_holds_cells: assert property (
        (i_clk_en && tck_rise && !active && !chain_shift_s)
        |=> ($stable(io_q) && $stable(ctrl_q)))
        else $error("cells moved while no operation was running");

    chk_equal_oe_bypass: assert property (
        (ctrl_q[47] == ctrl_q[46]) |-> !active)
        else $error("operation active with equal direction enables");

    chk_toggle_inverts: assert property (
        (i_clk_en && tck_rise && active && dir_ab
         && mode == brt_pkg::MODE_TOGGLE)
        |=> io_q[39:20] == ~$past(io_q[39:20]))
        else $error("toggle did not invert output cells");

    chk_toggle_samples: assert property (
        (i_clk_en && tck_rise && active && !dir_ab
         && mode == brt_pkg::MODE_TOGGLE)
        |=> io_q[39:20] == $past(b_s))
        else $error("toggle did not capture input pins");

    chk_count_steps: assert property (
        (i_clk_en && tck_rise && active && dir_ab
         && mode == brt_pkg::MODE_PSA_COUNT20)
        |=> io_q[39:20] == $past(io_q[39:20]) + 20'h1)
        else $error("count did not step by one");

    chk_pattern_nonzero: assert property (
        (i_clk_en && tck_rise && active && mode == brt_pkg::MODE_PRPG40
         && io_q != 40'h0)
        |=> (io_q != 40'h0 && io_q != $past(io_q)))
        else $error("pattern generator stalled on nonzero seed");

    chk_psa40_shadow_hold: assert property (
        (active && mode == brt_pkg::MODE_PSA40) [*2] |-> $stable(shadow_q))
        else $error("shadows changed during 40-bit signature");

    chk_in_shadow_hold: assert property (
        (active && dir_ab) [*2] |-> $stable(shadow_q[19:0]))
        else $error("input-side shadows changed during operation");

    chk_pattern_to_shadow: assert property (
        (i_clk_en && tck_fall && active && dir_ab
         && mode == brt_pkg::MODE_PSA_PRPG20)
        |=> shadow_q[39:20] == $past(io_q[39:20]))
        else $error("pattern not applied on falling edge");

    chk_ctrl_excluded: assert property (
        (active && !chain_shift_s) [*2] |-> $stable(ctrl_q))
        else $error("control cells altered by an algorithm");

    chk_opsel_stable: assert property (
        !(i_clk_en && tck_rise && opsel_shift_s) |=> $stable(opsel_q))
        else $error("select register changed without a shift");

    chk_decode_low_bits: assert property (
        (opsel_q[1:0] == 2'h2) |-> mode == brt_pkg::MODE_PSA40)
        else $error("top select bit changed a 40-bit decode");

    chk_freeze_holds: assert property (
        !i_clk_en |=> ($stable(io_q) && $stable(shadow_q)
                       && $stable(opsel_q) && $stable(ctrl_q)))
        else $error("state moved while the clock enable was low");

    chk_psa20_fold: assert property (
        (i_clk_en && tck_rise && active && dir_ab
         && mode == brt_pkg::MODE_PSA_PRPG20)
        |=> io_q[19:1] == ($past(io_q[18:0]) ^ $past(a_s[19:1])))
        else $error("input cells did not fold the pins into the signature");

    chk_count_steps_ba: assert property (
        (i_clk_en && tck_rise && active && !dir_ab
         && mode == brt_pkg::MODE_PSA_COUNT20)
        |=> io_q[19:0] == $past(io_q[19:0]) + 20'h1)
        else $error("b-to-a count did not step in the a cells");

    chk_pattern_ba_drive: assert property (
        (i_clk_en && tck_fall && active && !dir_ab
         && mode == brt_pkg::MODE_PRPG40)
        |=> shadow_q[19:0] == $past(io_q[19:0]))
        else $error("pattern not applied to the a pins on falling edge");

    cov_toggle_run: cover property (
        tck_rise && active && mode == brt_pkg::MODE_TOGGLE);
    cov_psa_ba: cover property (
        tck_rise && active && !dir_ab && mode == brt_pkg::MODE_PSA40);
    cov_count_ab: cover property (
        tck_fall && active && dir_ab && mode == brt_pkg::MODE_PSA_COUNT20);
    cov_toggle_ba: cover property (
        tck_rise && active && !dir_ab && mode == brt_pkg::MODE_TOGGLE);
endmodule : brt_engine
`default_nettype wire

/* File: rtl/brt_pkg.sv */
// constants, op-code decode and mode type for the boundary run-test engine
package brt_pkg;
    localparam int OPSEL_W = 3;
    localparam int HALF_W = 20;
    localparam int IO_W = 40;
    localparam int CTRL_HI = 47;
    localparam int CTRL_LO = 36;
    localparam int OE_AB_POS = 47;
    localparam int OE_BA_POS = 46;
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] OPSEL_RESET = 3'h0;
    localparam logic [11:0] CTRL_RESET = 12'hfff;
    localparam logic [39:0] IO_RESET = 40'h0;
    localparam logic [39:0] SHADOW_RESET = 40'h0;
    localparam logic [1:0] OP_LOW_TOGGLE = 2'h0;
    localparam logic [1:0] OP_LOW_PRPG40 = 2'h1;
    localparam logic [1:0] OP_LOW_PSA40 = 2'h2;
    localparam logic [2:0] OP_PSA_PRPG20 = 3'h3;
    localparam logic [2:0] OP_PSA_COUNT20 = 3'h7;
    // feedback taps, bit index within each register
    localparam int TAP40_A = 39;
    localparam int TAP40_B = 37;
    localparam int TAP40_C = 20;
    localparam int TAP40_D = 18;
    localparam int TAP20_A = 19;
    localparam int TAP20_B = 16;

    typedef enum logic [2:0] {
        MODE_TOGGLE,
        MODE_PRPG40,
        MODE_PSA40,
        MODE_PSA_PRPG20,
        MODE_PSA_COUNT20
    } brt_mode_t;

    function automatic brt_mode_t decode_op(input logic [2:0] op);
        brt_mode_t m;
        m = MODE_TOGGLE;
        if (op[1:0] == OP_LOW_TOGGLE) begin
            m = MODE_TOGGLE;
        end else if (op[1:0] == OP_LOW_PRPG40) begin
            m = MODE_PRPG40;
        end else if (op[1:0] == OP_LOW_PSA40) begin
            m = MODE_PSA40;
        end else if (op == OP_PSA_PRPG20) begin
            m = MODE_PSA_PRPG20;
        end else if (op == OP_PSA_COUNT20) begin
            m = MODE_PSA_COUNT20;
        end
        return m;
    endfunction : decode_op
endpackage : brt_pkg

/* File: rtl/brt_sync.sv */
// two-stage synchroniser bank for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module brt_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = i_clk_en ? i_async : meta_q;
        sync_d = i_clk_en ? meta_q : sync_q;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule : brt_sync
`default_nettype wire

/* File: tb/brt_jtag_model.sv */
// jtag controller model: tck frames, tap levels and serial scans
`timescale 1ns/1ps
`default_nettype none
module brt_jtag_model (
    input wire logic i_clock,
    input wire logic i_tdo_chain,
    input wire logic i_tdo_opsel,
    output logic o_tck,
    output logic o_tdi,
    output logic o_run_instr,
    output logic o_run_idle,
    output logic o_opsel_shift,
    output logic o_chain_shift,
    output logic o_chain_update
);
    initial begin
        {o_tck, o_tdi, o_run_instr, o_run_idle} = 4'h0;
        {o_opsel_shift, o_chain_shift, o_chain_update} = 3'h0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : wait_clk
    // tck stands low between frames; tdo read just before each rise
    task automatic cyc(output logic so_c, output logic so_o);
        so_c = i_tdo_chain;
        so_o = i_tdo_opsel;
        o_tck = 1'b1;
        wait_clk(4);
        o_tck = 1'b0;
        wait_clk(4);
    endtask : cyc
    // old contents leave as the new seed enters, then one update
    task automatic scan_chain(input logic [51:0] v, output logic [51:0] q);
        logic c;
        logic o;
        {o_run_instr, o_run_idle} = 2'h0;
        o_chain_shift = 1'b1;
        for (int k = 0; k < 52; k++) begin
            o_tdi = v[k];
            cyc(c, o);
            q[k] = c;
        end
        o_chain_shift = 1'b0;
        o_chain_update = 1'b1;
        o_tdi = ~o_tdi;
        cyc(c, o);
        o_chain_update = 1'b0;
    endtask : scan_chain
    task automatic scan_opsel(input logic [2:0] v, output logic [2:0] q);
        logic c;
        logic o;
        o_opsel_shift = 1'b1;
        for (int k = 0; k < 3; k++) begin
            o_tdi = v[k];
            cyc(c, o);
            q[k] = o;
        end
        o_opsel_shift = 1'b0;
    endtask : scan_opsel
    // select is always scanned before this is called
    task automatic run_test(input int n, input logic idle);
        logic c;
        logic o;
        o_run_instr = 1'b1;
        o_run_idle = idle;
        for (int k = 0; k < n; k++) begin
            o_tdi = ~o_tdi;
            cyc(c, o);
        end
    endtask : run_test
endmodule : brt_jtag_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the boundary run-test engine
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clock, i_rst, tck, tdi, r_in, r_id, s_op, s_ch, upd;
    logic [19:0] a_pin, b_pin, o_a_pin, o_b_pin;
    logic o_a_oe_n, o_b_oe_n, tdo_op, tdo_ch, o_test_active;
    logic [2:0] last_op;
    logic clk_en;
    int errors, n_tests, cycles;
    brt_engine dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(clk_en),
        .i_tck(tck), .i_tdi(tdi), .i_run_test_instr(r_in), .i_run_idle(r_id),
        .i_opsel_shift(s_op), .i_chain_shift(s_ch), .i_chain_update(upd),
        .i_a_pin(a_pin), .i_b_pin(b_pin), .o_a_pin(o_a_pin),
        .o_a_oe_n(o_a_oe_n), .o_b_pin(o_b_pin), .o_b_oe_n(o_b_oe_n),
        .o_opsel_tdo(tdo_op), .o_chain_tdo(tdo_ch),
        .o_test_active(o_test_active));
    brt_jtag_model jm_u (.i_clock(i_clock), .i_tdo_chain(tdo_ch),
        .i_tdo_opsel(tdo_op), .o_tck(tck), .o_tdi(tdi), .o_run_instr(r_in),
        .o_run_idle(r_id), .o_opsel_shift(s_op), .o_chain_shift(s_ch),
        .o_chain_update(upd));
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            conclude();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check
    function automatic logic [39:0] l40(input logic [39:0] v);
        return {v[38:0], v[39] ^ v[37] ^ v[20] ^ v[18]};
    endfunction : l40
    function automatic logic [19:0] l20(input logic [19:0] v);
        return {v[18:0], v[19] ^ v[16]};
    endfunction : l20
    // one rise; output half first, halves swap for b-to-a
    function automatic logic [39:0] nxt(input logic [2:0] op, input logic ab,
        input logic [39:0] io, input logic [19:0] p);
        logic [39:0] v;
        logic [39:0] r;
        v = ab ? io : {io[19:0], io[39:20]};
        r = {v[39:20] + 20'h1, l20(v[19:0]) ^ p};
        if (op[1:0] == 2'h0) r = {~v[39:20], p};
        else if (op[1:0] == 2'h1) r = l40(v);
        else if (op[1:0] == 2'h2) r = l40(v) ^ {20'h0, p};
        else if (op == 3'h3) r = {l20(v[39:20]), l20(v[19:0]) ^ p};
        return ab ? r : {r[19:0], r[39:20]};
    endfunction : nxt
    task automatic exercise(input logic [2:0] op, input logic [11:0] ct,
        input logic [39:0] seed, input int n, input logic idle);
        logic [51:0] q;
        logic [2:0] oq;
        logic [39:0] io;
        logic [39:0] sh;
        logic ab;
        logic act;
        jm_u.scan_chain({ct, seed}, q);
        jm_u.scan_opsel(op, oq);
        check(64'(oq), 64'(last_op));
        last_op = op;
        ab = ~ct[11];
        act = idle && (ct[11] != ct[10]);
        io = seed;
        sh = seed;
        for (int k = 0; k < n; k++) begin
            if (act) begin
                io = nxt(op, ab, io, ab ? a_pin : b_pin);
            end
        end
        if (act && op[1:0] != 2'h2 && ab) sh[39:20] = io[39:20];
        if (act && op[1:0] != 2'h2 && !ab) sh[19:0] = io[19:0];
        jm_u.run_test(n, idle);
        check(64'(o_test_active), 64'(act));
        check(64'({o_b_pin, o_a_pin}), 64'(sh));
        check(64'({o_b_oe_n, o_a_oe_n}), 64'(ct[11:10]));
        jm_u.scan_chain({12'hfff, 40'h0}, q);
        check(64'(q), 64'({ct, io}));
    endtask : exercise
    task automatic t_reset();
        logic [51:0] q;
        check(64'({o_b_oe_n, o_a_oe_n}), 64'h3);
        check(64'({o_b_pin, o_a_pin}), 64'(brt_pkg::SHADOW_RESET));
        jm_u.scan_chain({12'hfff, 40'h0}, q);
        check(64'(q), 64'({brt_pkg::CTRL_RESET, brt_pkg::IO_RESET}));
        $display("test reset done");
    endtask : t_reset
    task automatic t_toggle();
        exercise(3'h4, 12'h5a5, 40'h12345_6789a, 3, 1'b1);
        exercise(3'h0, 12'ha5a, 40'h8_7654_3210, 3, 1'b1);
        $display("test toggle done");
    endtask : t_toggle
    task automatic t_modes();
        logic [2:0] ops [6] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h5, 3'h6};
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < 6; k++) begin
                exercise(ops[k], d ? 12'ha5a : 12'h5a5,
                    40'h9_1234_abcd ^ 40'(k), 5, 1'b1);
            end
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_bypass();
        exercise(3'h1, 12'h3c3, 40'h7_0f0f_1234, 4, 1'b1);
        exercise(3'h2, 12'hfc3, 40'h3_5555_aaaa, 4, 1'b1);
        exercise(3'h1, 12'h5a5, 40'h1_2468_ace0, 4, 1'b0);
        exercise(3'h1, 12'ha5a, 40'h0, 4, 1'b1);
        $display("test bypass done");
    endtask : t_bypass
    // a stalled clock enable must swallow a whole scan and its update
    task automatic t_freeze();
        logic [51:0] keep;
        logic [51:0] q;
        keep = {12'h5a5, 40'h6_c3a5_0f1e};
        jm_u.scan_chain(keep, q);
        jm_u.wait_clk(4);
        clk_en = 1'b0;
        jm_u.scan_chain(~keep, q);
        check(64'({o_b_pin, o_a_pin}), 64'(keep[39:0]));
        jm_u.wait_clk(4);
        clk_en = 1'b1;
        jm_u.wait_clk(4);
        jm_u.scan_chain({12'hfff, 40'h0}, q);
        check(64'(q), 64'(keep));
        $display("test freeze done");
    endtask : t_freeze
    initial begin
        i_rst = 1'b1;
        clk_en = 1'b1;
        a_pin = 20'h5a3c1;
        b_pin = 20'hc3a5e;
        last_op = brt_pkg::OPSEL_RESET;
        repeat (12) @(posedge i_clock);
        #1 i_rst = 1'b0;
        jm_u.wait_clk(4);
        t_reset();
        t_toggle();
        t_modes();
        t_bypass();
        t_freeze();
        conclude();
    end
endmodule : tb
`default_nettype wire
